/* verilog/mcsr_regs.sv */
// Modem control/status register bank behind the muxed parallel bus.
// Assumes bus pins and detector levels are asynchronous to clk.
module mcsr_regs
    import mcsr_pkg::*;
#(
    parameter int         ALT_HALF  = MCSR_ALT_HALF,
    parameter logic [3:0] DEV_SIG   = 4'hF  // Arbitrary signature value
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] ad_in,
    output logic      [7:0] ad_out,
    output logic            ad_oe,
    input  wire logic       ale,
    input  wire logic       cs_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic       long_loop_in,
    input  wire logic       call_tone_in,
    input  wire logic       answer_tone_in,
    input  wire logic       carrier_in,
    input  wire logic       plain_mark_in,
    input  wire logic       rx_data_in,
    input  wire logic       txd_in,
    output logic            int_out,
    output logic            tx_data_out,
    output mcsr_txm_t       tx_mode,
    output logic     [11:0] dtmf_low_hz,
    output logic     [11:0] dtmf_high_hz,
    output logic     [11:0] ans_tone_hz,
    output logic            guard_on,
    output logic     [11:0] guard_hz,
    output logic            overspeed,
    output logic            ans_detect_ccitt,
    output logic            rxd_out,
    output logic            rxd_oe,
    output logic            rxd_pullup,
    output logic      [7:0] line_ctrl_out,
    output logic      [7:0] iface_ctrl_out
);

    // ==========================================================
    // Pin synchronisers
    logic [11:0] bus_s;
    logic [6:0]  line_s;
    logic [7:0]  ad_s;
    logic        ale_s;
    logic        cs_n_s;
    logic        rd_n_s;
    logic        wr_n_s;
    logic        txd_s;
    logic [5:0]  det_s;

    mcsr_sync #(.WIDTH(12), .INIT(32'h0000_0E00)) u_bus_sync (
        .clk  (clk),
        .rst  (rst),
        .din  ({wr_n, rd_n, cs_n, ale, ad_in}),
        .dout (bus_s)
    );

    mcsr_sync #(.WIDTH(7), .INIT(32'h0000_0000)) u_line_sync (
        .clk  (clk),
        .rst  (rst),
        .din  ({txd_in, rx_data_in, plain_mark_in, carrier_in,
                answer_tone_in, call_tone_in, long_loop_in}),
        .dout (line_s)
    );

    assign ad_s   = bus_s[7:0];
    assign ale_s  = bus_s[8];
    assign cs_n_s = bus_s[9];
    assign rd_n_s = bus_s[10];
    assign wr_n_s = bus_s[11];
    assign txd_s  = line_s[6];
    assign det_s  = line_s[5:0];

    // ==========================================================
    // Bus cycle tracking
    logic       ale_prev_q;
    logic       wr_n_prev_q;
    logic       rd_act_prev_q;
    logic [2:0] addr_q;
    logic       sel_q;
    logic       rd_act;
    logic       rd_start;
    logic       wr_done;

    // Address and chip select are captured on the falling edge of ALE
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ale_prev_q <= 1'b0;
            addr_q     <= MCSR_A_LINE;
            sel_q      <= 1'b0;
        end else begin
            ale_prev_q <= ale_s;
            if (ale_prev_q && !ale_s) begin
                addr_q <= ad_s[2:0];
                sel_q  <= !cs_n_s;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_n_prev_q   <= 1'b1;
            rd_act_prev_q <= 1'b0;
        end else begin
            wr_n_prev_q   <= wr_n_s;
            rd_act_prev_q <= rd_act;
        end
    end

    assign rd_act   = sel_q && !rd_n_s;
    assign rd_start = rd_act && !rd_act_prev_q;
    // Data is taken at the end of the strobe, where setup is specified
    assign wr_done  = sel_q && wr_n_s && !wr_n_prev_q;

    // ==========================================================
    // Writable registers
    logic [7:0] lc_q;
    logic [7:0] ic_q;
    logic [7:0] tc_q;
    logic       soft_rst;

    assign soft_rst = ic_q[MCSR_IC_RESET];

    // Soft reset bit clears all writable registers, itself included
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lc_q <= MCSR_REG_RST;
            ic_q <= MCSR_REG_RST;
            tc_q <= MCSR_REG_RST;
        end else if (soft_rst) begin
            lc_q <= MCSR_REG_RST;
            ic_q <= MCSR_REG_RST;
            tc_q <= MCSR_REG_RST;
        end else if (wr_done) begin
            unique case (addr_q)
                MCSR_A_LINE: begin
                    lc_q <= ad_s & ~(8'h01 << MCSR_LC_UNUSED);
                end
                MCSR_A_CTRL: ic_q <= ad_s;
                MCSR_A_TONE: tc_q <= ad_s;
                // Detect and signature ignore writes
                default:     lc_q <= lc_q;
            endcase
        end
    end

    assign line_ctrl_out  = lc_q;
    assign iface_ctrl_out = ic_q;

    logic tx_en;
    logic dtmf_bit;
    logic ans_bit;
    logic guard_bit;

    assign tx_en     = lc_q[MCSR_LC_TX_EN];
    assign dtmf_bit  = tc_q[MCSR_TC_DTMF];
    assign ans_bit   = tc_q[MCSR_TC_ANS];
    assign guard_bit = tc_q[MCSR_TC_GUARD];

    // ==========================================================
    // Detect register
    logic [7:0] det_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            det_q <= MCSR_REG_RST;
        end else begin
            det_q <= {2'b00, det_s};
        end
    end

    // ==========================================================
    // Read data
    logic [7:0] rd_data_q;
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        unique case (addr_q)
            MCSR_A_LINE: rd_mux = lc_q;
            MCSR_A_CTRL: rd_mux = ic_q;
            MCSR_A_DET:  rd_mux = det_q;
            MCSR_A_TONE: rd_mux = tc_q;
            MCSR_A_SIG:  rd_mux = {DEV_SIG, 4'h0} ;
            default:     rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data_q <= 8'h00;
        end else begin
            rd_data_q <= rd_mux;
        end
    end

    assign ad_out = rd_data_q;
    assign ad_oe  = rd_act;

    // ==========================================================
    // Detect interrupt
    logic [4:1] det_chg;
    logic       det_evt;
    logic       int_pend_q;
    logic       det_rd;

    assign det_chg = det_q[4:1] ^ det_s[4:1];
    // Answer/call masked while transmitting, carrier masked during DTMF
    assign det_evt = ((det_chg[1] || det_chg[2]) && !tx_en)
                   || (det_chg[3] && !dtmf_bit)
                   || det_chg[4];
    assign det_rd  = rd_start && (addr_q == MCSR_A_DET);

    // A new event in the read cycle keeps the flag set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_pend_q <= 1'b0;
        end else if (!ic_q[MCSR_IC_DET_IE]) begin
            int_pend_q <= 1'b0;
        end else if (det_evt) begin
            int_pend_q <= 1'b1;
        end else if (det_rd) begin
            int_pend_q <= 1'b0;
        end
    end

    assign int_out = int_pend_q && ic_q[MCSR_IC_DET_IE];

    // ==========================================================
    // Transmit data pattern
    localparam int ALT_W = $clog2(ALT_HALF + 1);
    logic [ALT_W-1:0] alt_cnt_q;
    logic             alt_q;
    logic             tx_data_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alt_cnt_q <= '0;
            alt_q     <= 1'b1;
        end else if (alt_cnt_q == ALT_W'(ALT_HALF - 1)) begin
            alt_cnt_q <= '0;
            alt_q     <= !alt_q;
        end else begin
            alt_cnt_q <= alt_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_data_q <= 1'b1;
        end else begin
            unique case (ic_q[MCSR_IC_PAT_LO +: 2])
                MCSR_PAT_DATA:  tx_data_q <= txd_s;
                MCSR_PAT_ALT:   tx_data_q <= alt_q;
                MCSR_PAT_MARK:  tx_data_q <= 1'b1;
                MCSR_PAT_SPACE: tx_data_q <= 1'b0;
            endcase
        end
    end

    assign tx_data_out = tx_data_q;

    // ==========================================================
    // Transmit source selection
    function automatic logic [23:0] dtmf_pair(input logic [3:0] code);
        logic [23:0] p;
        p = {MCSR_F_941, MCSR_F_1633};
        unique case (code)
            4'h1: p = {MCSR_F_697, MCSR_F_1209};
            4'h2: p = {MCSR_F_697, MCSR_F_1336};
            4'h3: p = {MCSR_F_697, MCSR_F_1477};
            4'h4: p = {MCSR_F_770, MCSR_F_1209};
            4'h5: p = {MCSR_F_770, MCSR_F_1336};
            4'h6: p = {MCSR_F_770, MCSR_F_1477};
            4'h7: p = {MCSR_F_852, MCSR_F_1209};
            4'h8: p = {MCSR_F_852, MCSR_F_1336};
            4'h9: p = {MCSR_F_852, MCSR_F_1477};
            4'hA: p = {MCSR_F_941, MCSR_F_1336};
            4'hB: p = {MCSR_F_941, MCSR_F_1209};
            4'hC: p = {MCSR_F_941, MCSR_F_1477};
            4'hD: p = {MCSR_F_697, MCSR_F_1633};
            4'hE: p = {MCSR_F_770, MCSR_F_1633};
            4'hF: p = {MCSR_F_852, MCSR_F_1633};
            4'h0: p = {MCSR_F_941, MCSR_F_1633};
        endcase
        return p;
    endfunction

    mcsr_txm_t   txm_q;
    mcsr_txm_t   txm_d;
    logic [23:0] dtmf_q;
    logic [11:0] ans_hz_q;
    logic        guard_on_q;
    logic [11:0] guard_hz_q;

    always_comb begin
        txm_d = MCSR_TXM_IDLE;
        if (!tx_en) begin
            txm_d = MCSR_TXM_IDLE;
        end else if (dtmf_bit) begin
            txm_d = MCSR_TXM_DTMF;
        end else if (ans_bit) begin
            txm_d = MCSR_TXM_ANS;
        end else begin
            txm_d = MCSR_TXM_DATA;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txm_q <= MCSR_TXM_IDLE;
        end else begin
            txm_q <= txm_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dtmf_q <= {MCSR_F_NONE, MCSR_F_NONE};
        end else if (dtmf_bit && tx_en) begin
            dtmf_q <= dtmf_pair(tc_q[3:0]);
        end else begin
            dtmf_q <= {MCSR_F_NONE, MCSR_F_NONE};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ans_hz_q <= MCSR_F_NONE;
        end else if (txm_d == MCSR_TXM_ANS) begin
            ans_hz_q <= tc_q[MCSR_TC_SEL] ? MCSR_F_2100 : MCSR_F_2225;
        end else begin
            ans_hz_q <= MCSR_F_NONE;
        end
    end

    // Guard tone rides on data, so DTMF or answer tone shuts it off
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            guard_on_q <= 1'b0;
            guard_hz_q <= MCSR_F_NONE;
        end else if (guard_bit && !ans_bit && !dtmf_bit && tx_en) begin
            guard_on_q <= 1'b1;
            guard_hz_q <= tc_q[MCSR_TC_SEL] ? MCSR_F_550 : MCSR_F_1800;
        end else begin
            guard_on_q <= 1'b0;
            guard_hz_q <= MCSR_F_NONE;
        end
    end

    assign tx_mode      = txm_q;
    assign dtmf_low_hz  = dtmf_q[23:12];
    assign dtmf_high_hz = dtmf_q[11:0];
    assign ans_tone_hz  = ans_hz_q;
    assign guard_on     = guard_on_q;
    assign guard_hz     = guard_hz_q;

    // ==========================================================
    // Receive path options
    logic ovsp_q;
    logic ccitt_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ovsp_q  <= 1'b0;
            ccitt_q <= 1'b0;
        end else begin
            ovsp_q  <= !dtmf_bit && tc_q[MCSR_TC_OVSP];
            // Detect frequency select; meaningful in originate only
            ccitt_q <= !dtmf_bit && !ans_bit && tc_q[MCSR_TC_SEL];
        end
    end

    assign overspeed        = ovsp_q;
    assign ans_detect_ccitt = ccitt_q;
    assign rxd_out          = det_q[5];
    assign rxd_oe           = !tc_q[MCSR_TC_RXD_OFF];
    assign rxd_pullup       = tc_q[MCSR_TC_RXD_OFF];

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_evt_enabled;
        ic_q[MCSR_IC_DET_IE] && det_evt;
    endsequence

    sequence s_dtmf_req;
        dtmf_bit && tx_en && !soft_rst && !wr_done;
    endsequence

    a_int_gate_off: assert property (
        !ic_q[MCSR_IC_DET_IE] |=> !int_pend_q && !int_out)
        else $error("interrupt active while detect enable clear");
    a_pat_mark: assert property (
        ic_q[MCSR_IC_PAT_LO +: 2] == MCSR_PAT_MARK |=> tx_data_out)
        else $error("mark pattern not sent");
    a_pat_data: assert property (
        ic_q[MCSR_IC_PAT_LO +: 2] == MCSR_PAT_DATA
        |=> tx_data_out == $past(txd_s))
        else $error("transmit data does not follow input");
    a_call_mirror: assert property (
        det_q[1] == $past(det_s[1]) && det_q[7:6] == 2'h0)
        else $error("call status bit wrong");
    a_rx_mirror: assert property (
        rxd_out == det_q[5] ##1 det_q[5] == $past(det_s[5]))
        else $error("receive data status not mirrored");
    a_dtmf_prio: assert property (
        s_dtmf_req |=> tx_mode == MCSR_TXM_DTMF && !guard_on
        && ans_tone_hz == MCSR_F_NONE)
        else $error("dtmf did not take priority");
    a_dtmf_off: assert property (
        !dtmf_bit |=> dtmf_low_hz == MCSR_F_NONE
        && tx_mode != MCSR_TXM_DTMF)
        else $error("dtmf active with bit clear");
    a_ans_freq: assert property (
        ans_bit && !dtmf_bit && tx_en
        |=> ans_tone_hz == ($past(tc_q[MCSR_TC_SEL]) ? MCSR_F_2100
                                                     : MCSR_F_2225))
        else $error("answer tone frequency wrong");
    a_guard_freq: assert property (
        guard_bit && !ans_bit && !dtmf_bit && tx_en
        |=> guard_on && guard_hz == ($past(tc_q[MCSR_TC_SEL]) ? MCSR_F_550
                                                     : MCSR_F_1800))
        else $error("guard tone frequency wrong");
    a_rxd_float: assert property (
        tc_q[MCSR_TC_RXD_OFF] |-> !rxd_oe && rxd_pullup)
        else $error("receive pin driven while disabled");
    a_int_raise: assert property (
        s_evt_enabled ##1 ic_q[MCSR_IC_DET_IE] |-> int_out)
        else $error("detect change did not raise interrupt");

endmodule

/* verilog/mcsr_pkg.sv */
// Shared constants for the modem control and status register bank.
// Assumes a single 250 MHz clock domain in the design that imports it.
package mcsr_pkg;

    // ==========================================================
    // Register addresses (three-bit index on the muxed bus)
    localparam logic [2:0] MCSR_A_LINE = 3'h0;
    localparam logic [2:0] MCSR_A_CTRL = 3'h1;
    localparam logic [2:0] MCSR_A_DET  = 3'h2;
    localparam logic [2:0] MCSR_A_TONE = 3'h3;
    localparam logic [2:0] MCSR_A_SIG  = 3'h6;

    // ==========================================================
    // Field positions
    localparam int MCSR_LC_TX_EN   = 1;
    localparam int MCSR_LC_UNUSED  = 6;
    localparam int MCSR_IC_PAT_LO  = 6;
    localparam int MCSR_IC_DET_IE  = 5;
    localparam int MCSR_IC_RESET   = 2;
    localparam int MCSR_TC_RXD_OFF = 7;
    localparam int MCSR_TC_GUARD   = 6;
    localparam int MCSR_TC_ANS     = 5;
    localparam int MCSR_TC_DTMF    = 4;
    localparam int MCSR_TC_OVSP    = 1;
    localparam int MCSR_TC_SEL     = 0;
    localparam int MCSR_SIG_LO     = 4;

    // ==========================================================
    // Reset values and counts
    localparam logic [7:0] MCSR_REG_RST  = 8'h00;
    localparam int         MCSR_ALT_HALF = 16;

    // ==========================================================
    // Transmit patterns
    localparam logic [1:0] MCSR_PAT_DATA  = 2'h0;
    localparam logic [1:0] MCSR_PAT_ALT   = 2'h1;
    localparam logic [1:0] MCSR_PAT_MARK  = 2'h2;
    localparam logic [1:0] MCSR_PAT_SPACE = 2'h3;

    // ==========================================================
    // Tone frequencies in Hz
    localparam logic [11:0] MCSR_F_697  = 12'h2B9;
    localparam logic [11:0] MCSR_F_770  = 12'h302;
    localparam logic [11:0] MCSR_F_852  = 12'h354;
    localparam logic [11:0] MCSR_F_941  = 12'h3AD;
    localparam logic [11:0] MCSR_F_1209 = 12'h4B9;
    localparam logic [11:0] MCSR_F_1336 = 12'h538;
    localparam logic [11:0] MCSR_F_1477 = 12'h5C5;
    localparam logic [11:0] MCSR_F_1633 = 12'h661;
    localparam logic [11:0] MCSR_F_2225 = 12'h8B1;
    localparam logic [11:0] MCSR_F_2100 = 12'h834;
    localparam logic [11:0] MCSR_F_1800 = 12'h708;
    localparam logic [11:0] MCSR_F_550  = 12'h226;
    localparam logic [11:0] MCSR_F_NONE = 12'h000;

    typedef enum logic [3:0] {
        MCSR_TXM_IDLE = 4'h1,
        MCSR_TXM_DATA = 4'h2,
        MCSR_TXM_DTMF = 4'h4,
        MCSR_TXM_ANS  = 4'h8
    } mcsr_txm_t;

endpackage

/* verilog/mcsr_sync.sv */
// Two-flop synchroniser for a group of asynchronous pin inputs.
// Assumes inputs are quasi-static levels; buses are not coherent.
module mcsr_sync #(
    parameter int          WIDTH = 1,
    parameter logic [31:0] INIT  = 32'h0000_0000
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_q;

    // ==========================================================
    // First stage feeds only the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= INIT[WIDTH-1:0];
            dout   <= INIT[WIDTH-1:0];
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end

endmodule

/* verification/mcsr_host.sv */
// Host model: drives the muxed register bus of the register bank.
// Assumes a free-running clk; pin levels are held five cycles, the read strobe six and the final release three.
module mcsr_host (
    input  wire logic       clk,
    input  wire logic [7:0] ad_out,
    input  wire logic       ad_oe,
    output logic      [7:0] ad_in,
    output logic            ale,
    output logic            cs_n,
    output logic            rd_n,
    output logic            wr_n
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        ale = 1'b0;
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        ad_in = 8'h00;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic addr(input logic [2:0] a);
        ale = 1'b1;
        cs_n = 1'b0;
        ad_in = {5'h00, a};
        step(5);
        ale = 1'b0;
        step(5);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        addr(a);
        wr_n = 1'b0;
        ad_in = d;
        step(5);
        wr_n = 1'b1;
        step(5);
        cs_n = 1'b1;
        // Released bus shows the inverse, never a stale copy
        ad_in = ~d;
        step(3);
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d,
                      output logic oe);
        addr(a);
        rd_n = 1'b0;
        ad_in = ~ad_in;
        step(6);
        d = ad_out;
        oe = ad_oe;
        rd_n = 1'b1;
        step(5);
        cs_n = 1'b1;
        step(3);
    endtask
endmodule

/* verification/tb.sv */
// Self-checking bench for the modem register bank.
// Assumes mcsr_host as bus master; detector pins driven here.
module tb;
    import mcsr_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0, rst = 1'b1, oe, int_out, tx_data_out;
    logic [7:0] ad_in, ad_out, rv, line_ctrl_out, iface_ctrl_out;
    logic ad_oe, ale, cs_n, rd_n, wr_n, guard_on, overspeed;
    logic ans_detect_ccitt, rxd_out, rxd_oe, rxd_pullup;
    logic long_loop_in, call_tone_in, answer_tone_in;
    logic carrier_in, plain_mark_in, rx_data_in, txd_in;
    logic [11:0] dtmf_low_hz, dtmf_high_hz, ans_tone_hz, guard_hz;
    mcsr_txm_t tx_mode;
    int fails = 0, checks = 0;

    always #2 clk = ~clk;

    // Signature 4'hF is arbitrary
    mcsr_regs #(.ALT_HALF(2), .DEV_SIG(4'hF)) DUT (
        .clk, .rst, .ad_in, .ad_out, .ad_oe, .ale, .cs_n, .rd_n, .wr_n,
        .long_loop_in, .call_tone_in, .answer_tone_in, .carrier_in,
        .plain_mark_in, .rx_data_in, .txd_in, .int_out, .tx_data_out,
        .tx_mode, .dtmf_low_hz, .dtmf_high_hz, .ans_tone_hz, .guard_on,
        .guard_hz, .overspeed, .ans_detect_ccitt, .rxd_out, .rxd_oe,
        .rxd_pullup, .line_ctrl_out, .iface_ctrl_out);
    mcsr_host host (.clk, .ad_out, .ad_oe, .ad_in, .ale, .cs_n,
        .rd_n, .wr_n);

    task automatic wrap_up;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [2:0] a, input logic [7:0] e);
        host.rd(a, rv, oe);
        chk(rv, e);
        chk(oe, 1'b1);
    endtask

    task automatic wait_int;
        int n;
        n = 0;
        while (int_out !== 1'b1 && n < 40) begin
            host.step(1);
            n++;
        end
        chk(int_out, 1'b1);
        if (n == 40) wrap_up();
    endtask

    function automatic logic [11:0] row_f(input int c);
        logic [11:0] r [4];
        r = '{MCSR_F_697, MCSR_F_770, MCSR_F_852, MCSR_F_941};
        if (c == 0) return r[3];
        return c > 12 ? r[c-13] : r[(c-1)/3];
    endfunction

    function automatic logic [11:0] col_f(input int c);
        logic [11:0] k [3];
        k = '{MCSR_F_1209, MCSR_F_1336, MCSR_F_1477};
        case (c)
            0, 13, 14, 15: return MCSR_F_1633;
            10: return k[1];
            11: return k[0];
            12: return k[2];
            default: return k[(c-1)%3];
        endcase
    endfunction

    task automatic tone(input logic [7:0] v, input logic [11:0] a,
                        input logic [11:0] g, input logic on);
        host.wr(MCSR_A_TONE, v);
        host.step(4);
        chk(ans_tone_hz, a);
        chk(guard_hz, g);
        chk(guard_on, on);
    endtask

    task automatic t_regs;
        rchk(MCSR_A_CTRL, 8'h00);
        host.wr(MCSR_A_TONE, 8'h0A);
        rchk(MCSR_A_TONE, 8'h0A);
        host.wr(MCSR_A_DET, 8'hFF);
        rchk(MCSR_A_DET, 8'h00);
        host.wr(MCSR_A_SIG, 8'h55);
        rchk(MCSR_A_SIG, 8'hF0);
        rchk(3'h5, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_detect;
        {rx_data_in, plain_mark_in, carrier_in, answer_tone_in,
         call_tone_in, long_loop_in} = 6'h2B;
        rchk(MCSR_A_DET, 8'h2B);
        chk(rxd_out, 1'b1);
        chk(int_out, 1'b0);
        host.wr(MCSR_A_TONE, 8'h80);
        chk(rxd_oe, 1'b0);
        chk(rxd_pullup, 1'b1);
        {rx_data_in, plain_mark_in, carrier_in, answer_tone_in,
         call_tone_in, long_loop_in} = 6'h14;
        rchk(MCSR_A_DET, 8'h14);
        chk(int_out, 1'b0);
        $display("test detect done");
    endtask

    task automatic t_int;
        host.wr(MCSR_A_CTRL, 8'h20);
        chk(iface_ctrl_out, 8'h20);
        rchk(MCSR_A_DET, 8'h14);
        chk(int_out, 1'b0);
        // Unmasked detect bit 4 must change to raise the interrupt
        plain_mark_in = 1'b0;
        wait_int();
        rchk(MCSR_A_DET, 8'h04);
        chk(int_out, 1'b0);
        // Unused line control bit 6 must store as 0
        host.wr(MCSR_A_LINE, 8'h43);
        chk(line_ctrl_out, 8'h03);
        call_tone_in = 1'b1;
        host.step(10);
        chk(int_out, 1'b0);
        $display("test interrupt done");
    endtask

    task automatic t_pattern;
        int n;
        txd_in = 1'b1;
        host.wr(MCSR_A_CTRL, 8'h00);
        chk(tx_data_out, 1'b1);
        txd_in = 1'b0;
        host.step(4);
        chk(tx_data_out, 1'b0);
        host.wr(MCSR_A_CTRL, 8'h80);
        chk(tx_data_out, 1'b1);
        host.wr(MCSR_A_CTRL, 8'hC0);
        chk(tx_data_out, 1'b0);
        host.wr(MCSR_A_CTRL, 8'h40);
        n = 0;
        repeat (16) begin
            rv[0] = tx_data_out;
            host.step(1);
            if (tx_data_out !== rv[0]) n++;
        end
        chk(16'(n), 16'h0008);
        $display("test pattern done");
    endtask

    task automatic t_tones;
        host.wr(MCSR_A_LINE, 8'h02);
        for (int c = 0; c < 16; c++) begin
            tone(8'h70 | 8'(c), 12'h000, 12'h000, 1'b0);
            chk(dtmf_low_hz, row_f(c));
            chk(dtmf_high_hz, col_f(c));
            chk(tx_mode, MCSR_TXM_DTMF);
        end
        chk(overspeed, 1'b0);
        tone(8'h20, MCSR_F_2225, 12'h000, 1'b0);
        chk(tx_mode, MCSR_TXM_ANS);
        tone(8'h21, MCSR_F_2100, 12'h000, 1'b0);
        tone(8'h40, 12'h000, MCSR_F_1800, 1'b1);
        chk(tx_mode, MCSR_TXM_DATA);
        tone(8'h41, 12'h000, MCSR_F_550, 1'b1);
        chk(ans_detect_ccitt, 1'b1);
        tone(8'h02, 12'h000, 12'h000, 1'b0);
        chk(dtmf_low_hz, 12'h000);
        chk(overspeed, 1'b1);
        // Reset bit clears line, interface and tone registers
        host.wr(MCSR_A_CTRL, 8'h04);
        chk(line_ctrl_out, 8'h00);
        chk(iface_ctrl_out, 8'h00);
        rchk(MCSR_A_TONE, 8'h00);
        host.wr(MCSR_A_LINE, 8'h00);
        tone(8'h1F, 12'h000, 12'h000, 1'b0);
        chk(dtmf_high_hz, 12'h000);
        chk(tx_mode, MCSR_TXM_IDLE);
        $display("test tones done");
    endtask

    initial begin
        {txd_in, rx_data_in, plain_mark_in, carrier_in, answer_tone_in,
         call_tone_in, long_loop_in} = 7'h00;
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        t_regs();
        t_detect();
        t_int();
        t_pattern();
        t_tones();
        wrap_up();
    end
endmodule
